// file: drk_consts.svh
// Constants for the ramp and amplitude keying block: bit positions, reset values, timing.
// Assumes a single 20 MHz system clock; the DDS tick is that clock divided by 24.
`ifndef DRK_CONSTS_SVH
`define DRK_CONSTS_SVH
`define DRK_CR1_KEY_EN_BIT    8
`define DRK_CR1_KEY_EXT_BIT   9
`define DRK_CR1_LOAD_RATE_BIT 15
`define DRK_CR2_RAMP_EN_BIT   19
`define DRK_CR2_DEST_LO_BIT   20
`define DRK_CR2_DEST_HI_BIT   21
`define DRK_DEST_FREQ         2'h0
`define DRK_DEST_PHASE        2'h1
`define DRK_PHASE_LSB         18
`define DRK_AMP_LSB           20
`define DRK_DDS_DIV           24
`define DRK_DIV_W             5
`define DRK_ACC_RESET         32'h00000000
`define DRK_RATE_RESET        16'h0000
`endif

// file: drk_ctl_model.sv
// Model of the outside controller that drives the keying, ramp and profile pins.
// Assumes the bench sets the wanted pin levels; pins move just after a rising edge.
`timescale 1ns/1ps
module drk_ctl_model (
  // Clock
  input  wire logic       clk,
  // Wanted pin levels from the bench
  input  wire logic       want_key,
  input  wire logic       want_dir,
  input  wire logic       want_hold,
  input  wire logic [2:0] want_sel,
  // Pins toward the block
  output logic            amplitude_keying_pin,
  output logic            ramp_direction_pin,
  output logic            ramp_hold_pin,
  output logic [2:0]      profile_sel
);
  // ==========================================================================
  // Pin drivers
  // Pins start low so the block sees defined levels from time zero.
  initial begin
    amplitude_keying_pin = 1'b0;
    ramp_direction_pin = 1'b0;
    ramp_hold_pin = 1'b0;
    profile_sel = 3'h0;
  end
  // Wanted levels are taken at the edge and shown 1 ns later, so bench and model never race.
  always @(posedge clk) begin
    amplitude_keying_pin <= #1 want_key;
    ramp_direction_pin   <= #1 want_dir;
    ramp_hold_pin        <= #1 want_hold;
    profile_sel          <= #1 want_sel;
  end
endmodule // drk_ctl_model

// file: drk_pkg.sv
// Types shared by the ramp and amplitude keying block.
// Assumes drk_consts.svh is included by drk_ramp and drk_top, the design users of these types.
package drk_pkg;
  // ==========================================================================
  // Profile parameters presented by the active profile.
  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [11:0] amp;
  } drk_param_type;

  // Ramp programming: five 32-bit registers.
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] step_up;
    logic [31:0] step_down;
    logic [15:0] rate_down;
    logic [15:0] rate_up;
  } drk_ramp_cfg_type;

  // Ramp control bits, latched at each input/output update.
  typedef struct packed {
    logic       enable;
    logic [1:0] dest;
    logic       clear;
    logic       autoclear;
    logic       load_rate;
  } drk_ramp_ctl_type;

  typedef enum logic [1:0] {
    DRK_IDLE,
    DRK_RUN,
    DRK_CLEARED
  } drk_state_type;
endpackage

// file: drk_ramp.sv
// Ramp accumulator with limit clamp, per-slope step size and step interval.
// Assumes a DDS tick pulse of one system clock every 24 cycles from the parent.
`timescale 1ns/1ps
`include "drk_consts.svh"
module drk_ramp
  import drk_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             tick,
  input  wire drk_ramp_ctl_type ctl,
  input  wire logic             ctl_load,
  input  wire drk_ramp_cfg_type cfg,
  input  wire logic             dir,
  input  wire logic             hold,
  // Result
  output logic [31:0]           ramp_out
);
  // ==========================================================================
  // Accumulator and interval timer.
  logic [31:0]   acc_reg, acc_next;
  logic [15:0]   timer_reg, timer_next;
  logic          dir_reg, dir_next;
  drk_state_type state_reg, state_next;
  logic [32:0]   sum;
  logic [31:0]   clamped;

  // Next state; the clamp sits in the feedback path, and a clear loads the lower limit directly.
  always_comb begin
    acc_next   = acc_reg;
    timer_next = timer_reg;
    dir_next   = dir;
    state_next = state_reg;
    sum        = '0;
    clamped    = acc_reg;
    unique case (state_reg)
      DRK_IDLE: begin
        acc_next = `DRK_ACC_RESET;
        if (ctl_load && ctl.enable) begin
          state_next = DRK_RUN;
          acc_next   = cfg.lower;
          timer_next = dir ? cfg.rate_up : cfg.rate_down;
        end
      end
      DRK_RUN, DRK_CLEARED: begin
        if (ctl_load) begin
          if (ctl.load_rate) begin
            timer_next = dir ? cfg.rate_up : cfg.rate_down;
          end
        end
        if (ctl_load && !ctl.enable) begin
          state_next = DRK_IDLE;
        end else if (ctl.clear || (ctl_load && ctl.autoclear)) begin
          state_next = DRK_CLEARED;
          acc_next   = cfg.lower;
        end else if (dir != dir_reg) begin
          timer_next = dir ? cfg.rate_up : cfg.rate_down;
          state_next = DRK_RUN;
        end else if (tick && !hold) begin
          state_next = DRK_RUN;
          if (timer_reg <= 16'h0001) begin
            timer_next = dir ? cfg.rate_up : cfg.rate_down;
            if (dir) begin
              sum = {1'b0, acc_reg} + {1'b0, cfg.step_up};
              clamped = (sum[32] || sum[31:0] > cfg.upper) ? cfg.upper : sum[31:0];
            end else begin
              sum = {1'b0, acc_reg} - {1'b0, cfg.step_down};
              clamped = (sum[32] || sum[31:0] < cfg.lower) ? cfg.lower : sum[31:0];
            end
            acc_next = clamped;
          end else begin
            timer_next = timer_reg - 16'h0001;
          end
        end
      end
      default: state_next = DRK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg   <= `DRK_ACC_RESET;
      timer_reg <= `DRK_RATE_RESET;
      dir_reg   <= 1'b0;
      state_reg <= DRK_IDLE;
    end else begin
      acc_reg   <= acc_next;
      timer_reg <= timer_next;
      dir_reg   <= dir_next;
      state_reg <= state_next;
    end
  end

  // The output is held inside the current limits even if they are reprogrammed.
  always_comb begin
    if (acc_reg > cfg.upper) begin
      ramp_out = cfg.upper;
    end else if (acc_reg < cfg.lower) begin
      ramp_out = cfg.lower;
    end else begin
      ramp_out = acc_reg;
    end
  end

  AST_HOLD_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == DRK_RUN && hold && !ctl_load && !ctl.clear && dir == dir_reg
     && $stable(cfg)) |=> $stable(acc_reg))
    else $error("Ramp moved while hold was high.");
  AST_UP_MONOTONE: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == DRK_RUN && dir && dir_reg && !ctl_load && !ctl.clear && $stable(cfg))
    |=> acc_reg >= $past(acc_reg))
    else $error("Ramp fell while direction was up.");
endmodule // drk_ramp

// file: drk_top.sv
// Amplitude keying and digital ramp control producing DDS core parameters.
// Assumes all pins and config bits are synchronous to clk; ramp control bits are applied on io_update, keying bits and ramp_cfg at once.
`timescale 1ns/1ps
`include "drk_consts.svh"
module drk_top
  import drk_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Configuration registers
  input  wire logic [31:0]      control_register_one,
  input  wire logic [31:0]      control_register_two,
  input  wire logic             ramp_clear,
  input  wire logic             ramp_autoclear,
  input  wire drk_ramp_cfg_type ramp_cfg,
  input  wire logic             io_update,
  // Profiles
  input  wire drk_param_type    profile_param,
  input  wire logic [11:0]      profile_amplitude_scale_word [8],
  input  wire logic [2:0]       profile_sel,
  // Pins
  input  wire logic             amplitude_keying_pin,
  input  wire logic             ramp_direction_pin,
  input  wire logic             ramp_hold_pin,
  // DDS core parameters and status
  output drk_param_type         dds_param,
  output logic                  ramp_active,
  output logic                  keying_active
);
  // ==========================================================================
  // DDS clock divider: one tick every 24 system clocks, stopped when ramp is off.
  logic [`DRK_DIV_W-1:0] div_reg, div_next;
  logic                  tick;
  drk_ramp_ctl_type      ctl_reg, ctl_next, ctl_live;
  drk_param_type         param_next;
  logic [31:0]           ramp_out;
  logic                  key_en, key_ext;

  assign tick = (div_reg == `DRK_DIV_W'(`DRK_DDS_DIV - 1));

  always_comb begin
    div_next = div_reg;
    if (ctl_reg.enable) begin
      div_next = tick ? '0 : div_reg + `DRK_DIV_W'(1);
    end else begin
      div_next = '0;
    end
  end

  // Ramp control bits are sampled only at io_update, never on the raw write.
  always_comb begin
    ctl_live.enable    = control_register_two[`DRK_CR2_RAMP_EN_BIT];
    ctl_live.dest      = control_register_two[`DRK_CR2_DEST_HI_BIT:`DRK_CR2_DEST_LO_BIT];
    ctl_live.clear     = ramp_clear;
    ctl_live.autoclear = ramp_autoclear;
    ctl_live.load_rate = control_register_one[`DRK_CR1_LOAD_RATE_BIT];
    ctl_next = io_update ? ctl_live : ctl_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      ctl_reg <= '0;
    end else begin
      div_reg <= div_next;
      ctl_reg <= ctl_next;
    end
  end

  // ==========================================================================
  // Ramp core; it sees the control word being latched so enable acts at the update.
  drk_ramp u_ramp (
    .clk      (clk),
    .resetn   (resetn),
    .tick     (tick),
    .ctl      (io_update ? ctl_live : ctl_reg),
    .ctl_load (io_update),
    .cfg      (ramp_cfg),
    .dir      (ramp_direction_pin),
    .hold     (ramp_hold_pin),
    .ramp_out (ramp_out)
  );

  // ==========================================================================
  // Keying bits act immediately; they are not part of the ramp's update gating.
  assign key_en  = control_register_one[`DRK_CR1_KEY_EN_BIT];
  assign key_ext = control_register_one[`DRK_CR1_KEY_EXT_BIT];

  // Parameter selection: profile first, then ramp destination, then keying on top.
  always_comb begin
    param_next = profile_param;
    if (ctl_reg.enable) begin
      unique case (ctl_reg.dest)
        `DRK_DEST_FREQ:  param_next.freq = ramp_out;
        `DRK_DEST_PHASE: param_next.phase = {ramp_out[31:`DRK_PHASE_LSB], 2'h0};
        default:         param_next.amp = ramp_out[31:`DRK_AMP_LSB];
      endcase
    end
    if (key_en) begin
      // The external pin only steers the value when both enables are set.
      if (key_ext && !amplitude_keying_pin) begin
        param_next.amp = 12'h000;
      end else begin
        param_next.amp = profile_amplitude_scale_word[profile_sel];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dds_param     <= '0;
      ramp_active   <= 1'b0;
      keying_active <= 1'b0;
    end else begin
      dds_param     <= param_next;
      ramp_active   <= ctl_reg.enable;
      keying_active <= key_en;
    end
  end

  AST_KEY_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (key_en && key_ext && !amplitude_keying_pin) |=> dds_param.amp == 12'h000)
    else $error("Keying pin low did not force zero amplitude.");
  AST_KEY_SCALE: assert property (@(posedge clk) disable iff (!resetn)
    (key_en && (!key_ext || amplitude_keying_pin))
    |=> dds_param.amp == $past(profile_amplitude_scale_word[profile_sel]))
    else $error("Keying amplitude is not the selected scale word.");
  AST_KEY_OVERRIDE: assert property (@(posedge clk) disable iff (!resetn)
    (key_en && ctl_reg.enable && ctl_reg.dest[1] && (!key_ext || amplitude_keying_pin))
    |=> dds_param.amp == $past(profile_amplitude_scale_word[profile_sel]))
    else $error("Ramp amplitude beat the keying unit.");
  AST_KEY_OFF: assert property (@(posedge clk) disable iff (!resetn)
    (!key_en && !ctl_reg.enable) |=> dds_param == $past(profile_param))
    else $error("Keying acted while disabled.");
  AST_RAMP_FREQ: assert property (@(posedge clk) disable iff (!resetn)
    (ctl_reg.enable && ctl_reg.dest == `DRK_DEST_FREQ)
    |=> dds_param.freq == $past(ramp_out) && dds_param.phase == $past(profile_param.phase))
    else $error("Frequency destination not routed.");
  AST_RAMP_PHASE: assert property (@(posedge clk) disable iff (!resetn)
    (ctl_reg.enable && ctl_reg.dest == `DRK_DEST_PHASE)
    |=> dds_param.phase[15:2] == $past(ramp_out[31:18])
        && dds_param.freq == $past(profile_param.freq))
    else $error("Phase destination misaligned.");
  AST_RAMP_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
    ctl_reg.enable && ramp_cfg.upper > ramp_cfg.lower
    |-> ramp_out <= ramp_cfg.upper && ramp_out >= ramp_cfg.lower)
    else $error("Ramp output outside limits.");
  AST_ENABLE_AT_UPDATE: assert property (@(posedge clk) disable iff (!resetn)
    !io_update |=> ctl_reg == $past(ctl_reg))
    else $error("Ramp control changed without an update.");
  AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!resetn)
    tick && ctl_reg.enable |=> !tick [*8])
    else $error("DDS tick came early.");
  AST_CLOCK_STOP: assert property (@(posedge clk) disable iff (!resetn)
    !ctl_reg.enable |=> div_reg == '0)
    else $error("Ramp divider ran while disabled.");
endmodule // drk_top

// file: test_dds_ramp_and_amplitude_keying.sv
// Self-checking bench for the ramp and amplitude keying block.
// Assumes drk_pkg is compiled first and drk_ctl_model drives the pins.
`timescale 1ns/1ps
module test_dds_ramp_and_amplitude_keying;
  import drk_pkg::*;
  // ==========================================================================
  // Signals
  logic             clk, resetn, io_update, ramp_clear, ramp_auto, chk_lim;
  logic             want_key, want_dir, want_hold, key_pin, dir_pin, hold_pin;
  logic [2:0]       want_sel, sel;
  logic [31:0]      cr1, cr2, rng, r, f0;
  logic [63:0]      r64;
  logic [11:0]      amplitude_scale_word [8];
  drk_param_type    prof, dds_param;
  drk_ramp_cfg_type cfg;
  logic             ramp_active, keying_active;
  int               err_total, n_checks;
  localparam logic [31:0] LO = 32'h12345678;
  localparam logic [31:0] HI = 32'h12347678;
  localparam logic [31:0] STP = 32'h00000100;

  // ==========================================================================
  // Clock, design and pin model
  always #25 clk = ~clk;
  drk_top DUT (.clk(clk), .resetn(resetn), .control_register_one(cr1),
    .control_register_two(cr2), .ramp_clear(ramp_clear), .ramp_autoclear(ramp_auto),
    .ramp_cfg(cfg), .io_update(io_update), .profile_param(prof),
    .profile_amplitude_scale_word(amplitude_scale_word), .profile_sel(sel),
    .amplitude_keying_pin(key_pin), .ramp_direction_pin(dir_pin),
    .ramp_hold_pin(hold_pin), .dds_param(dds_param), .ramp_active(ramp_active),
    .keying_active(keying_active));
  drk_ctl_model ctl (.clk(clk), .want_key(want_key), .want_dir(want_dir),
    .want_hold(want_hold), .want_sel(want_sel), .amplitude_keying_pin(key_pin),
    .ramp_direction_pin(dir_pin), .ramp_hold_pin(hold_pin), .profile_sel(sel));

  // ==========================================================================
  // Helpers
  function logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // Expected amplitude: models keying only with both enable bits set; the bench never sets bit 8 without bit 9.
  function automatic logic [11:0] exp_amp(input logic [31:0] c, input logic p,
                                          input logic [2:0] s, input logic [11:0] b);
    if (c[8] && c[9]) return p ? amplitude_scale_word[s] : 12'h000;
    return b;
  endfunction
  // Expected parameters with the ramp value placed MSB-aligned at its destination.
  function automatic drk_param_type exp_param(input logic [1:0] d, input logic [31:0] v);
    drk_param_type p;
    p = prof;
    if (d == 2'h0) p.freq = v;
    else if (d == 2'h1) p.phase = {v[31:18], 2'h0};
    else p.amp = v[31:20];
    return p;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task upd;
    io_update = 1'b1;
    cyc(1);
    io_update = 1'b0;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task in_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if (!(got >= lo && got <= hi)) begin
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      err_total++;
    end
  endtask
  task complete_run;
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Limit watch: sampled mid-cycle while a frequency ramp runs.
  always @(negedge clk) begin
    if (chk_lim) in_range(dds_param.freq, LO, HI);
  end
  // Watchdog well beyond the few thousand cycles the sequence needs.
  initial begin
    #2000000;
    err_total++;
    complete_run;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 0; resetn = 0; io_update = 0; ramp_clear = 0; ramp_auto = 0; chk_lim = 0;
    want_key = 0; want_dir = 0; want_hold = 0; want_sel = 3'h0;
    cr1 = 32'h0; cr2 = 32'h0; err_total = 0; n_checks = 0; rng = 32'h1766715f;
    cfg = '{upper: HI, lower: LO, step_up: STP, step_down: 32'h200,
            rate_down: 16'h1, rate_up: 16'h1};
    r64 = {nxt(), nxt()};
    prof = r64[59:0];
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      amplitude_scale_word[i] = r[31:20];
    end
    repeat (8) @(posedge clk);
    #1 resetn = 1;
    cyc(3);
    chk(dds_param, prof);
    chk(ramp_active, 1'b0);
    // Random keying settings with the ramp off.
    for (int i = 0; i < 40; i++) begin
      r = nxt();
      r64 = {nxt(), nxt()};
      prof = r64[59:0];
      cr1 = {22'h0, r[9] | r[8], r[8], 8'h0};
      want_key = r[10];
      want_sel = r[13:11];
      cyc(3);
      chk(dds_param.amp, exp_amp(cr1, want_key, want_sel, prof.amp));
      chk({dds_param.freq, dds_param.phase}, {prof.freq, prof.phase});
      chk(keying_active, cr1[8]);
    end
    cr1 = 32'h0;
    // Enable without an update must not start the ramp.
    cr2 = 32'h00080000;
    cyc(30);
    chk(dds_param, prof);
    chk(ramp_active, 1'b0);
    // Each destination code, ramp parked at the lower limit.
    for (int d = 0; d < 4; d++) begin
      cr2 = {10'h0, d[1:0], 1'b1, 19'h0};
      upd;
      cyc(60);
      chk(dds_param, exp_param(d[1:0], LO));
      chk(ramp_active, 1'b1);
    end
    // Keying overrides the ramp on the amplitude destination.
    cr1 = 32'h00000300;
    want_key = 1'b1;
    cyc(3);
    chk(dds_param.amp, amplitude_scale_word[want_sel]);
    cr1 = 32'h0;
    // Rising sweep with hold in the middle.
    cr2 = 32'h00080000;
    upd;
    cyc(5);
    chk_lim = 1'b1;
    want_dir = 1'b1;
    cyc(24 * 8);
    in_range(dds_param.freq, LO + STP, HI - STP);
    want_hold = 1'b1;
    cyc(3);
    f0 = dds_param.freq;
    cyc(100);
    chk(dds_param.freq, f0);
    want_hold = 1'b0;
    cyc(24 * 40);
    chk(dds_param.freq, HI);
    want_dir = 1'b0;
    cyc(24 * 24);
    chk(dds_param.freq, LO);
    // Slower rising interval: a step every 4 ticks of 24 clocks.
    cfg.rate_up = 16'h4;
    cr1 = 32'h00008000;
    upd;
    want_dir = 1'b1;
    cyc(24 * 4 * 5);
    in_range(dds_param.freq, LO + 4 * STP, LO + 6 * STP);
    // Autoclear presets the lower limit once, then the rising sweep carries on.
    ramp_auto = 1'b1;
    upd;
    ramp_auto = 1'b0;
    cyc(1);
    chk(dds_param.freq, LO);
    cyc(24 * 4 * 3);
    in_range(dds_param.freq, LO + STP, LO + 4 * STP);
    // Clear holds the output at the lower limit.
    ramp_clear = 1'b1;
    upd;
    cyc(30);
    chk(dds_param.freq, LO);
    ramp_clear = 1'b0;
    chk_lim = 1'b0;
    // Disable: parameters fall back to the profile.
    cr2 = 32'h0;
    upd;
    cyc(3);
    chk(dds_param, prof);
    chk(ramp_active, 1'b0);
    complete_run;
  end
endmodule // test_dds_ramp_and_amplitude_keying
